// [core/mth_pkg.sv]
// constants, codes and register map of the measurement telegram handler
// Notes on behaviour
// - The request kind sits in header byte 0 as 0x00 group 0 read, 0x10 single read, 0x20 group read, 0x30 group definition, 0x40 command, 0x60 parameter read.
// - A variant without parameter reading answers type 0x60 as an unsupported type and serves nothing.
// - Type 0x00 is handled exactly like a group read of group number zero.
// - Each response repeats the type in bits 6 to 4 of byte 0, keeps bit 7 clear and carries the status nibble in bits 3 to 0.
// - Byte 3 and the user data of a request are ignored, except the member list of a group definition.
// - A single read response echoes id and data_set_index, gives the value byte count in the top nibble of byte 2 and common status in byte 3.
// - Multi-byte values go out high byte first or low byte first as the configured format selects.
// - A group definition response echoes group_number and data_set_index, reports length zero and common status in byte 3.
// - Every request and response is 16 bytes: four header bytes and twelve user data bytes.
// - On an error no user data goes out, length is zero, the status nibble holds the code and a higher code wins.
// - An invalid type answers status 0x09 and a bad data_set_index in a single or group read answers status 0x02.
package mth_pkg;
  // telegram geometry
  localparam int         TEL_BYTES  = 16;
  localparam int         HDR_BYTES  = 4;
  localparam int         DATA_BYTES = 12;
  localparam logic [3:0] LAST_BYTE  = 4'hf;
  localparam logic [3:0] DS_NONE    = 4'h0;
  // request kinds, bits 6 to 4 of byte 0
  localparam logic [2:0] TYPE_ZERO   = 3'h0;
  localparam logic [2:0] TYPE_SINGLE = 3'h1;
  localparam logic [2:0] TYPE_GROUP  = 3'h2;
  localparam logic [2:0] TYPE_SET    = 3'h3;
  localparam logic [2:0] TYPE_CMD    = 3'h4;
  localparam logic [2:0] TYPE_PARAM  = 3'h6;
  // status nibble codes
  localparam logic [3:0] ST_OK      = 4'h0;
  localparam logic [3:0] ST_DSID    = 4'h2;
  localparam logic [3:0] ST_TOOBIG  = 4'h4;
  localparam logic [3:0] ST_NOGROUP = 4'h5;
  localparam logic [3:0] ST_NOMEAS  = 4'h6;
  localparam logic [3:0] ST_BADSET  = 4'h8;
  localparam logic [3:0] ST_BADTYPE = 4'h9;
  // measurand table and groups
  localparam int         N_MEAS   = 8;
  localparam int         N_GROUPS = 4;
  localparam logic [1:0] SZ_NONE  = 2'h0;
  localparam logic [1:0] SZ_4     = 2'h3;
  // apb register offsets
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_IRQ_ST    = 12'h004;
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h008;
  localparam logic [11:0] OFF_STATE     = 12'h00c;
  localparam logic [11:0] OFF_SIZES     = 12'h010;
  localparam logic [11:0] OFF_COMMON    = 12'h014;
  localparam logic [11:0] OFF_VALUE     = 12'h020;
  localparam logic [11:0] OFF_VALUE_END = 12'h040;
  // field positions
  localparam int CTRL_LITTLE = 0;
  localparam int CTRL_PARAM  = 1;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_ERR     = 1;
  localparam int IRQ_BADTYPE = 2;
  // reset values
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam logic [2:0]  IRQ_MASK_RST = 3'h0;
  localparam logic [15:0] SIZES_RST    = 16'h0000;
  localparam logic [6:0]  COMMON_RST   = 7'h00;
  // sequencer states
  typedef enum logic [3:0] {
    S_RECV   = 4'b0001,
    S_EXEC   = 4'b0010,
    S_GATHER = 4'b0100,
    S_SEND   = 4'b1000
  } mth_state_t;
endpackage

// [core/mth_value_bytes.sv]
// orders the bytes of one measured value for the response user data
`timescale 1ns/1ns
`default_nettype none
module mth_value_bytes
  import mth_pkg::*;
(
  input  wire logic [31:0]     value,
  input  wire logic [1:0]      sizeCode,
  input  wire logic            littleEnd,
  output logic      [3:0][7:0] bytesOut,
  output logic      [2:0]      byteCount
);
  // size code 1, 2 or 3 means 1, 2 or 4 bytes; unused lanes read zero
  always_comb begin
    byteCount = (sizeCode == SZ_4) ? 3'h4 : {1'b0, sizeCode};
    for (int k = 0; k < 4; k++) begin
      if (3'(k) >= byteCount) begin
        bytesOut[k] = 8'h00;
      end else if (littleEnd) begin
        bytesOut[k] = value[8*k +: 8];
      end else begin
        bytesOut[k] = value[8*(int'(byteCount) - 1 - k) +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// [core/mth_telegram_handler.sv]
// measurement telegram handler: apb registers, request decode and response build
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module mth_telegram_handler
  import mth_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  output logic             rxReady,
  output logic             txValid,
  output logic      [7:0]  txData,
  input  wire logic        txReady,
  output logic             irq
);
  typedef struct packed {
    mth_state_t                          st;
    logic [3:0]                          cnt;
    logic [TEL_BYTES-1:0][7:0]           req;
    logic [DATA_BYTES-1:0][7:0]          data;
    logic [4:0]                          fill;
    logic [3:0]                          mIdx;
    logic [3:0]                          stat;
    logic [2:0]                          typ;
    logic [1:0]                          grp;
    logic [7:0]                          common;
    logic [N_GROUPS-1:0][DATA_BYTES-1:0][3:0] members;
    logic [N_GROUPS-1:0][3:0]            gCnt;
    logic [1:0]                          ctrl;
    logic [15:0]                         sizes;
    logic [6:0]                          commonIn;
    logic [N_MEAS-1:0][31:0]             values;
    logic [2:0]                          irqSt;
    logic [2:0]                          irqMask;
    logic [31:0]                         prdata;
    logic                                pready;
    logic                                pslverr;
    logic                                irq;
    logic                                rxReady;
    logic                                txValid;
    logic [7:0]                          txData;
  } mth_regs_t;
  localparam mth_regs_t REGS_RST = '{
    st:       S_RECV,
    rxReady:  1'b1,
    ctrl:     CTRL_RST,
    irqMask:  IRQ_MASK_RST,
    sizes:    SIZES_RST,
    commonIn: COMMON_RST,
    default:  '0
  };
  mth_regs_t r;
  mth_regs_t n;
  // size code of a measurand; ids outside the table count as absent
  function automatic logic [1:0] sizeOf(input logic [7:0] id, input logic [15:0] sz);
    logic [2:0] e;
    e = 3'(id - 8'h01);
    if (id == 8'h00 || id > 8'(N_MEAS)) begin
      return SZ_NONE;
    end
    return sz[2*e +: 2];
  endfunction
  // bytes taken by a size code
  function automatic logic [5:0] szBytes(input logic [1:0] sc);
    return (sc == SZ_4) ? 6'h04 : {4'h0, sc};
  endfunction
  // the higher status code overrides the lower one
  function automatic logic [3:0] maxStat(input logic [3:0] a, input logic [3:0] b);
    return (a > b) ? a : b;
  endfunction
  function automatic logic isValue(input logic [11:0] a);
    return a >= OFF_VALUE && a < OFF_VALUE_END;
  endfunction
  function automatic logic [2:0] valIdx(input logic [11:0] a);
    return 3'((a - OFF_VALUE) >> 2);
  endfunction
  // word-aligned known offsets only; everything else gets pslverr
  function automatic logic mapped(input logic [11:0] a);
    return a[1:0] == 2'h0 && (a == OFF_CTRL || a == OFF_IRQ_ST || a == OFF_IRQ_MASK
      || a == OFF_STATE || a == OFF_SIZES || a == OFF_COMMON || isValue(a));
  endfunction
  function automatic logic [31:0] readReg(input mth_regs_t s, input logic [11:0] a);
    if (a == OFF_CTRL) return {30'h0000_0000, s.ctrl};
    if (a == OFF_IRQ_ST) return {29'h0000_0000, s.irqSt};
    if (a == OFF_IRQ_MASK) return {29'h0000_0000, s.irqMask};
    if (a == OFF_STATE) return {21'h00_0000, s.st, s.typ, s.stat};
    if (a == OFF_SIZES) return {16'h0000, s.sizes};
    if (a == OFF_COMMON) return {25'h000_0000, s.commonIn};
    if (isValue(a)) return s.values[valIdx(a)];
    return 32'h0000_0000;
  endfunction
  // response byte i: header first, then the user data
  function automatic logic [7:0] outByte(input mth_regs_t s, input logic [3:0] i);
    if (i == 4'h0) return {1'b0, s.typ, s.stat};
    if (i == 4'h1) return s.req[1];
    if (i == 4'h2) return {s.fill[3:0], s.req[2][3:0]};
    if (i == 4'h3) return s.common;
    return s.data[i - 4'h4];
  endfunction

  // one byte-ordering path shared by single reads and group gathering
  logic [7:0]      vbId;
  logic [1:0]      vbSize;
  logic [3:0][7:0] vbBytes;
  logic [2:0]      vbCount;

  assign vbId   = (r.st == S_GATHER) ? {4'h0, r.members[r.grp][r.mIdx]} : r.req[1];
  assign vbSize = sizeOf(vbId, r.sizes);

  mth_value_bytes u_value_bytes (
    .value     (r.values[valIdx(OFF_VALUE + {2'h0, vbId - 8'h01, 2'h0})]),
    .sizeCode  (vbSize),
    .littleEnd (r.ctrl[CTRL_LITTLE]),
    .bytesOut  (vbBytes),
    .byteCount (vbCount)
  );
  // next state of the whole block
  always_comb begin
    logic [3:0] err;
    logic [7:0] gSel;
    logic [5:0] total;
    logic [3:0] cntReq;
    logic       toSend;
    logic       done;
    logic [2:0] clr;
    n      = r;
    err    = ST_OK;
    gSel   = 8'h00;
    total  = 6'h00;
    cntReq = r.req[2][7:4];
    toSend = 1'b0;
    done   = 1'b0;
    clr    = 3'h0;
    // apb: answer prepared in setup, so every access phase lasts one cycle
    n.pready = 1'b0;
    if (psel && !penable) begin
      n.pready  = 1'b1;
      n.pslverr = !mapped(paddr);
      // refused addresses read zero, unaligned ones in the value window too
      n.prdata  = mapped(paddr) ? readReg(r, paddr) : 32'h0000_0000;
    end
    if (psel && penable && r.pready && pwrite && !r.pslverr) begin
      if (paddr == OFF_CTRL) n.ctrl = pwdata[1:0];
      if (paddr == OFF_IRQ_ST) clr = pwdata[2:0];
      if (paddr == OFF_IRQ_MASK) n.irqMask = pwdata[2:0];
      if (paddr == OFF_SIZES) n.sizes = pwdata[15:0];
      if (paddr == OFF_COMMON) n.commonIn = pwdata[6:0];
      if (isValue(paddr)) n.values[valIdx(paddr)] = pwdata;
    end
    // telegram sequencer
    unique case (r.st)
      S_RECV: begin
        if (rxValid && r.rxReady) begin
          n.req[r.cnt] = rxData;
          n.cnt = r.cnt + 4'h1;
          if (r.cnt == LAST_BYTE) begin
            n.rxReady = 1'b0;
            n.st = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        // bits 3 to 0 of byte 0 and byte 3 never steer anything
        n.typ    = r.req[0][6:4];
        n.fill   = 5'h00;
        n.data   = '0;
        n.mIdx   = 4'h0;
        n.common = {1'b0, r.commonIn};
        unique case (r.req[0][6:4])
          TYPE_ZERO, TYPE_GROUP: begin
            gSel = (r.req[0][6:4] == TYPE_ZERO) ? 8'h00 : r.req[1];
            if (gSel >= 8'(N_GROUPS) || r.gCnt[gSel[1:0]] == 4'h0) begin
              err = ST_NOGROUP;
            end
            if (r.req[2][3:0] == DS_NONE) begin
              err = maxStat(err, ST_DSID);
            end
            n.grp = gSel[1:0];
            if (err == ST_OK) begin
              n.st = S_GATHER;
            end else begin
              toSend = 1'b1;
            end
          end
          TYPE_SINGLE: begin
            if (r.req[2][3:0] == DS_NONE) begin
              err = ST_DSID;
            end
            if (vbSize == SZ_NONE) begin
              err = maxStat(err, ST_NOMEAS);
            end
            if (err == ST_OK) begin
              n.data[3:0] = vbBytes;
              n.fill = {2'h0, vbCount};
            end
            toSend = 1'b1;
          end
          TYPE_SET: begin
            // the member list is the only request user data that is read
            if (r.req[1] >= 8'(N_GROUPS) || cntReq == 4'h0 || cntReq > 4'(DATA_BYTES)) begin
              err = ST_BADSET;
            end
            for (int k = 0; k < DATA_BYTES; k++) begin
              if (4'(k) < cntReq) begin
                if (sizeOf(r.req[HDR_BYTES+k], r.sizes) == SZ_NONE) begin
                  err = ST_BADSET;
                end
                total = total + szBytes(sizeOf(r.req[HDR_BYTES+k], r.sizes));
              end
            end
            // a member list too large for one response is refused up front
            if (total > 6'(DATA_BYTES)) begin
              err = ST_BADSET;
            end
            if (err == ST_OK) begin
              n.gCnt[r.req[1][1:0]] = cntReq;
              for (int k = 0; k < DATA_BYTES; k++) begin
                n.members[r.req[1][1:0]][k] = (4'(k) < cntReq) ? r.req[HDR_BYTES+k][3:0] : 4'h0;
              end
            end
            toSend = 1'b1;
          end
          TYPE_CMD: begin
            toSend = 1'b1;
          end
          TYPE_PARAM: begin
            if (!r.ctrl[CTRL_PARAM]) begin
              err = ST_BADTYPE;
            end
            toSend = 1'b1;
          end
          default: begin
            err    = ST_BADTYPE;
            toSend = 1'b1;
          end
        endcase
        n.stat = err;
      end
      S_GATHER: begin
        // one member per cycle appended behind the bytes already placed
        if (vbSize == SZ_NONE) begin
          err = ST_NOMEAS;
        end else if (r.fill + {2'h0, vbCount} > 5'(DATA_BYTES)) begin
          err = ST_TOOBIG;
        end else begin
          for (int k = 0; k < 4; k++) begin
            if (3'(k) < vbCount) begin
              n.data[4'(r.fill) + 4'(k)] = vbBytes[k];
            end
          end
          n.fill = r.fill + {2'h0, vbCount};
        end
        n.mIdx = r.mIdx + 4'h1;
        if (err != ST_OK) begin
          n.data = '0;
          n.fill = 5'h00;
        end
        if (err != ST_OK || n.mIdx == r.gCnt[r.grp]) begin
          toSend = 1'b1;
        end
        n.stat = err;
      end
      S_SEND: begin
        if (r.txValid && txReady) begin
          n.cnt    = r.cnt + 4'h1;
          n.txData = outByte(r, r.cnt + 4'h1);
          if (r.cnt == LAST_BYTE) begin
            n.txValid = 1'b0;
            n.rxReady = 1'b1;
            n.st      = S_RECV;
            done      = 1'b1;
          end
        end
      end
      default: begin
        n.st      = S_RECV;
        n.cnt     = 4'h0;
        n.rxReady = 1'b1;
        n.txValid = 1'b0;
      end
    endcase
    // start of the single response for this request
    if (toSend) begin
      n.st      = S_SEND;
      n.cnt     = 4'h0;
      n.txValid = 1'b1;
      n.txData  = outByte(n, 4'h0);
    end
    // sticky events; a set in the clearing cycle survives the clear
    n.irqSt = r.irqSt & ~clr;
    n.irqSt[IRQ_DONE] = n.irqSt[IRQ_DONE] | done;
    n.irqSt[IRQ_ERR] = n.irqSt[IRQ_ERR] | (done && r.stat != ST_OK);
    n.irqSt[IRQ_BADTYPE] = n.irqSt[IRQ_BADTYPE] | (done && r.stat == ST_BADTYPE);
    n.irq = |(r.irqSt & r.irqMask);
  end
  // all state in one register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= REGS_RST;
    end else begin
      r <= n;
    end
  end
  // every output straight from the register
  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
  assign rxReady = r.rxReady;
  assign txValid = r.txValid;
  assign txData  = r.txData;
  assign irq     = r.irq;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_hdr0;
    r.txValid && r.cnt == 4'h0 |-> r.txData == {1'b0, r.typ, r.stat};
  endproperty
  a_hdr0: assert property (p_hdr0) else $error("response byte 0 wrong");
  property p_noParam;
    r.st == S_EXEC && r.req[0][6:4] == TYPE_PARAM && !r.ctrl[CTRL_PARAM]
      |=> r.txValid && r.txData[3:0] == ST_BADTYPE;
  endproperty
  a_noParam: assert property (p_noParam) else $error("parameter read served");
  property p_zeroGroup;
    r.st == S_EXEC && r.req[0][6:4] == TYPE_ZERO && r.gCnt[0] != 4'h0 && r.req[2][3:0] != DS_NONE
      |=> r.st == S_GATHER && r.grp == 2'h0;
  endproperty
  a_zeroGroup: assert property (p_zeroGroup) else $error("type zero not on group 0");
  property p_errLen;
    r.txValid && r.cnt == 4'h2 && r.stat != ST_OK |-> r.txData[7:4] == 4'h0;
  endproperty
  a_errLen: assert property (p_errLen) else $error("error response has data");
  // byte 0 is shown only until the first handshake, so look at it at once
  property p_dsErr;
    r.st == S_EXEC && r.req[0][6:4] == TYPE_SINGLE && r.req[2][3:0] == DS_NONE
      |=> r.txValid && r.stat >= ST_DSID && r.txData[3:0] == r.stat;
  endproperty
  a_dsErr: assert property (p_dsErr) else $error("bad index not reported");
  property p_echo;
    r.txValid && r.cnt == 4'h1 |-> r.txData == r.req[1];
  endproperty
  a_echo: assert property (p_echo) else $error("byte 1 not echoed");
  property p_echoDs;
    r.txValid && r.cnt == 4'h2 |-> r.txData[3:0] == r.req[2][3:0];
  endproperty
  a_echoDs: assert property (p_echoDs) else $error("data set index not echoed");
  property p_setLen;
    r.txValid && r.cnt == 4'h2 && r.typ == TYPE_SET |-> r.txData[7:4] == 4'h0;
  endproperty
  a_setLen: assert property (p_setLen) else $error("group definition length not zero");
  property p_oneResp;
    rxValid && r.rxReady && r.cnt == LAST_BYTE |=> !r.rxReady [*2];
  endproperty
  a_oneResp: assert property (p_oneResp) else $error("request taken during processing");
  // the done bit is sticky, so it is tested as set, not as rising
  property p_len16;
    r.txValid && txReady && r.cnt == LAST_BYTE |=> !r.txValid && r.rxReady && r.irqSt[IRQ_DONE];
  endproperty
  a_len16: assert property (p_len16) else $error("response not 16 bytes");
endmodule
`default_nettype wire

// [testbench/mth_head_model.sv]
// head module model: sends request telegrams and collects the responses
`timescale 1ns/1ns
`default_nettype none
module mth_head_model (
  input  wire logic         clk,
  input  wire logic         rxReady,
  output logic              rxValid,
  output logic      [7:0]   rxData,
  input  wire logic         txValid,
  input  wire logic [7:0]   txData,
  output logic              txReady,
  output logic      [127:0] resp
);
  // idle link at time zero
  initial begin
    rxValid = 1'b0;
    rxData  = 8'h00;
    txReady = 1'b0;
    resp    = '0;
  end

  // one whole request, then one whole response; slow stalls every response byte
  task automatic exchange(input logic [127:0] req, input bit slow);
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      rxValid <= 1'b1;
      rxData  <= req[127-8*i -: 8];
      do @(posedge clk); while (rxReady !== 1'b1);
    end
    // released line shows the inverse so a stale byte cannot pass
    rxValid <= 1'b0;
    rxData  <= ~req[7:0];
    for (int i = 0; i < 16; i++) begin
      if (slow) begin
        txReady <= 1'b0;
        repeat (2) @(posedge clk);
      end
      txReady <= 1'b1;
      do @(posedge clk); while (txValid !== 1'b1);
      resp[127-8*i -: 8] = txData;
    end
    txReady <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [testbench/mth_telegram_handler_bench.sv]
// self-checking bench of the measurement telegram handler
`timescale 1ns/1ns
`default_nettype none
module mth_telegram_handler_bench;
  import mth_pkg::*;
  logic         clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic         rxValid, rxReady, txValid, txReady, irq, erv;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rdv;
  logic [7:0]   rxData, txData;
  logic [127:0] resp;
  int           failures, n_checks;
  // ignored request user data, deliberately not zero
  localparam logic [95:0] FILL   = {12{8'ha5}};
  localparam logic [7:0]  TY [5] = '{8'h40, 8'h50, 8'h70, 8'h60, 8'h60};
  localparam logic [7:0]  ST [5] = '{8'h00, 8'h09, 8'h09, 8'h09, 8'h00};

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  mth_telegram_handler uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxValid(rxValid),
    .rxData(rxData), .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady), .irq(irq));
  mth_head_model head (.clk(clk), .rxReady(rxReady), .rxValid(rxValid), .rxData(rxData), .txValid(txValid),
    .txData(txData), .txReady(txReady), .resp(resp));

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // apb transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tel(input logic [31:0] hdr, input logic [95:0] dat, input logic [127:0] exp, input bit slow);
    head.exchange({hdr, dat}, slow);
    chk(resp, exp);
  endtask

  task automatic t_reset;
    chk({rxReady, txValid, irq}, 3'b100);
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk({erv, rdv}, 33'h0);
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk({erv, rdv}, {1'b1, 32'h0});
    $display("test reset done");
  endtask

  task automatic t_single;
    apb(1'b0, OFF_VALUE, 32'h0000_0000);
    chk(rdv, 32'h1122_3344);
    tel({8'h1f, 8'h02, 8'h01, 8'haa}, FILL, {32'h1002_2105, 16'h5566, 80'h0}, 1'b0);
    // state word: idle state code, last type single, status ok
    apb(1'b0, OFF_STATE, 32'h0000_0000);
    chk(rdv, 32'h0000_0090);
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    tel({8'h10, 8'h02, 8'h01, 8'h00}, FILL, {32'h1002_2105, 16'h6655, 80'h0}, 1'b1);
    tel({8'h10, 8'h01, 8'h01, 8'h00}, FILL, {32'h1001_4105, 32'h4433_2211, 64'h0}, 1'b0);
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    tel({8'h10, 8'h02, 8'h00, 8'h00}, FILL, {32'h1202_0005, 96'h0}, 1'b0);
    tel({8'h10, 8'h05, 8'h00, 8'h00}, FILL, {32'h1605_0005, 96'h0}, 1'b0);
    $display("test single done");
  endtask

  task automatic t_group;
    tel({8'h30, 8'h01, 8'h30, 8'h00}, {24'h01_0203, 72'ha5}, {32'h3001_0005, 96'h0}, 1'b0);
    tel({8'h20, 8'h01, 8'h01, 8'h00}, FILL, {32'h2001_7105, 56'h11_2233_4455_6677, 40'h0}, 1'b1);
    tel({8'h00, 8'h00, 8'h01, 8'h00}, FILL, {32'h0500_0105, 96'h0}, 1'b0);
    tel({8'h30, 8'h00, 8'h10, 8'h00}, {8'h03, 88'ha5}, {32'h3000_0005, 96'h0}, 1'b0);
    repeat (2) tel({8'h00, 8'h00, 8'h01, 8'h00}, FILL, {32'h0000_1105, 8'h77, 88'h0}, 1'b0);
    $display("test group done");
  endtask

  task automatic t_types;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFF_CTRL, (i == 4) ? 32'h0000_0002 : 32'h0000_0000);
      tel({TY[i], 24'h00_0100}, FILL, {TY[i] | ST[i], 24'h00_0105, 96'h0}, 1'b0);
    end
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    $display("test types done");
  endtask

  // sticky status, mask and level output
  task automatic t_irq;
    apb(1'b1, OFF_IRQ_ST, 32'h0000_0007);
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_0004);
    tel({8'h50, 24'h00_0100}, FILL, {32'h5900_0105, 96'h0}, 1'b0);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b0, OFF_IRQ_ST, 32'h0000_0000);
    chk(rdv, 32'h0000_0007);
    apb(1'b1, OFF_IRQ_ST, 32'h0000_0004);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b1, OFF_IRQ_ST, 32'h0000_0003);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    $display("test irq done");
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    reset_n = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    apb(1'b1, OFF_SIZES, 32'h0000_001b);
    apb(1'b1, OFF_COMMON, 32'h0000_0005);
    apb(1'b1, OFF_VALUE, 32'h1122_3344);
    apb(1'b1, 12'h024, 32'h0000_5566);
    apb(1'b1, 12'h028, 32'h0000_0077);
    t_single;
    t_group;
    t_types;
    t_irq;
    close_out;
  end

  // watchdog, far beyond the several hundred cycles the tests need
  initial begin
    #100000;
    failures++;
    close_out;
  end
endmodule
`default_nettype wire
